// >>> ccs_status_target.sv
/*
 * Serial (two-wire) target that serves the charger status register
 * pair: address match, register pointer, auto-incrementing reads,
 * writes acknowledged and discarded.
 * Assumes SCL and SDA_I are synchronous to CLK and that each SCL
 * high and low phase spans at least four CLK periods.
 */
// What this block does
// - power good when above lockouts, below overvoltage
// - live bit 6 follows taper mode
// - live bit 5 follows charge done
// - live bit 4 follows input current limit
// - live bit 3 follows power-path current reduction
// - live bit 2 follows input voltage regulation
// - live bit 1 follows thermal regulation
// - fault bit 7 follows input overvoltage
// - fault bit 5 follows battery overcurrent
// - fault bit 4 high when battery undervoltage
// - fault bits 3 and 0 cold, hot regions
// - fault bit 2 thermistor cool region
// - fault bit 1 thermistor warm region
// - live status at 0x0, read-only, bit7 reserved
// - fault status at 0x1, read-only, bit6 reserved
// - answer at seven-bit target address 0x6B
`timescale 1ns/10ps
`default_nettype none
module ccs_status_target
	import ccs_pkg::*;
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic SCL,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	input wire ccs_cond_s COND
);

	ccs_state_e state;
	logic scl_q;
	logic scl_prev;
	logic sda_q;
	logic sda_prev;
	logic [2:0] bit_cnt;
	logic ack_phase;
	logic rd_dir;
	logic [7:0] rx_shift;
	logic [7:0] tx_shift;
	logic [7:0] reg_ptr;
	logic [7:0] rd_data;

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic rx_state;
	logic ack_state;
	logic byte_in_done;
	logic ack_start;
	logic ack_end;
	logic [7:0] rx_byte;
	logic addr_match;

	// line sampling and edge history
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			scl_q <= 1'b1;
			scl_prev <= 1'b1;
			sda_q <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_q <= SCL;
			scl_prev <= scl_q;
			sda_q <= SDA_I;
			sda_prev <= sda_q;
		end
	end

	assign scl_rise = scl_q & ~scl_prev;
	assign scl_fall = ~scl_q & scl_prev;
	// start and stop are data edges while the clock stays high
	assign bus_start = scl_q & scl_prev & sda_prev & ~sda_q;
	assign bus_stop = scl_q & scl_prev & ~sda_prev & sda_q;

	assign rx_state = (state == CCS_ADDR) || (state == CCS_PTR) || (state == CCS_WDATA);
	assign ack_state = (state == CCS_ADDR_ACK) || (state == CCS_PTR_ACK)
		|| (state == CCS_WDATA_ACK);
	assign byte_in_done = rx_state & scl_rise & (bit_cnt == 3'h7);
	assign ack_start = ack_state & scl_fall & ~ack_phase;
	assign ack_end = ack_state & scl_fall & ack_phase;
	assign rx_byte = {rx_shift[6:0], sda_q};
	assign addr_match = (rx_byte[7:1] == CCS_TARGET_ADDR);

	// transaction sequencing
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			state <= CCS_IDLE;
		end else if (bus_start) begin
			state <= CCS_ADDR;
		end else if (bus_stop) begin
			state <= CCS_IDLE;
		end else begin
			unique case (state)
				CCS_IDLE: begin
					state <= CCS_IDLE;
				end
				CCS_ADDR: begin
					if (byte_in_done) begin
						// other targets' traffic is ignored until the next start
						state <= addr_match ? CCS_ADDR_ACK : CCS_IDLE;
					end
				end
				CCS_ADDR_ACK: begin
					if (ack_end) begin
						state <= rd_dir ? CCS_RDATA : CCS_PTR;
					end
				end
				CCS_PTR: begin
					if (byte_in_done) begin
						state <= CCS_PTR_ACK;
					end
				end
				CCS_PTR_ACK: begin
					if (ack_end) begin
						state <= CCS_WDATA;
					end
				end
				CCS_WDATA: begin
					if (byte_in_done) begin
						state <= CCS_WDATA_ACK;
					end
				end
				CCS_WDATA_ACK: begin
					if (ack_end) begin
						state <= CCS_WDATA;
					end
				end
				CCS_RDATA: begin
					if (scl_fall && bit_cnt == 3'h7) begin
						state <= CCS_RD_ACK;
					end
				end
				CCS_RD_ACK: begin
					if (scl_rise && sda_q) begin
						// not acknowledged: the host ends the read
						state <= CCS_IDLE;
					end else if (scl_fall && ack_phase) begin
						state <= CCS_RDATA;
					end
				end
			endcase
		end
	end

	// bit counting, both directions
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			bit_cnt <= 3'h0;
		end else if (bus_start || bus_stop) begin
			bit_cnt <= 3'h0;
		end else if (rx_state && scl_rise) begin
			bit_cnt <= bit_cnt + 3'h1;
		end else if (state == CCS_RDATA && scl_fall) begin
			bit_cnt <= bit_cnt + 3'h1;
		end
	end

	// ack slot tracking: set when a target ack slot opens or a host ack is sampled, cleared when the slot closes
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			ack_phase <= 1'b0;
		end else if (bus_start || bus_stop) begin
			ack_phase <= 1'b0;
		end else if (ack_start) begin
			ack_phase <= 1'b1;
		end else if (ack_end) begin
			ack_phase <= 1'b0;
		end else if (state == CCS_RD_ACK && scl_rise && !sda_q) begin
			ack_phase <= 1'b1;
		end else if (state == CCS_RD_ACK && scl_fall && ack_phase) begin
			ack_phase <= 1'b0;
		end
	end

	// incoming bits
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			rx_shift <= 8'h00;
		end else if (rx_state && scl_rise) begin
			rx_shift <= rx_byte;
		end
	end

	// direction bit of the address byte
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			rd_dir <= 1'b0;
		end else if (state == CCS_ADDR && byte_in_done) begin
			rd_dir <= sda_q;
		end
	end

	// register pointer; status is read-only so written bytes only advance it
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			reg_ptr <= CCS_LIVE_OFS;
		end else if (state == CCS_PTR && byte_in_done) begin
			reg_ptr <= rx_byte;
		end else if (state == CCS_WDATA && byte_in_done) begin
			reg_ptr <= reg_ptr + 8'h01;
		end else if (state == CCS_RD_ACK && scl_rise) begin
			reg_ptr <= reg_ptr + 8'h01;
		end
	end

	// outgoing byte, loaded when its first bit goes out
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			tx_shift <= 8'h00;
		end else if (state == CCS_ADDR_ACK && ack_end && rd_dir) begin
			tx_shift <= rd_data;
		end else if (state == CCS_RD_ACK && scl_fall && ack_phase) begin
			tx_shift <= rd_data;
		end else if (state == CCS_RDATA && scl_fall) begin
			tx_shift <= {tx_shift[6:0], 1'b0};
		end
	end

	// data line drive: the line is only ever pulled low, never driven high
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			SDA_OE <= 1'b0;
		end else if (bus_start || bus_stop) begin
			SDA_OE <= 1'b0;
		end else begin
			unique case (state)
				CCS_ADDR_ACK, CCS_PTR_ACK, CCS_WDATA_ACK: begin
					if (ack_start) begin
						SDA_OE <= 1'b1;
					end else if (ack_end) begin
						SDA_OE <= (state == CCS_ADDR_ACK) && rd_dir && !rd_data[7];
					end
				end
				CCS_RDATA: begin
					if (scl_fall) begin
						SDA_OE <= (bit_cnt != 3'h7) && !tx_shift[6];
					end
				end
				CCS_RD_ACK: begin
					if (scl_fall && ack_phase) begin
						SDA_OE <= !rd_data[7];
					end
				end
				CCS_IDLE, CCS_ADDR, CCS_PTR, CCS_WDATA: begin
					SDA_OE <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			SDA_O <= CCS_SDA_LOW;
		end else begin
			SDA_O <= CCS_SDA_LOW;
		end
	end

	ccs_status_capture u_capture (
		.clk(CLK),
		.rst_n(RSTN),
		.cond(COND),
		.rd_ptr(reg_ptr),
		.rd_data(rd_data)
	);

endmodule
`default_nettype wire

// >>> ccs_pkg.sv
/*
 * Shared constants and types of the charger status register pair:
 * target address, register offsets, bit positions, reset value,
 * the live condition bundle and the serial target states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package ccs_pkg;

	// 7-bit serial target address
	localparam logic [6:0] CCS_TARGET_ADDR = 7'h6B;

	// register offsets
	localparam logic [7:0] CCS_LIVE_OFS = 8'h00;
	localparam logic [7:0] CCS_FAULT_OFS = 8'h01;

	// charger_live_status bit positions
	localparam int CCS_LIVE_RSVD_BIT = 7;
	localparam int CCS_TAPER_BIT = 6;
	localparam int CCS_DONE_BIT = 5;
	localparam int CCS_ILIM_BIT = 4;
	localparam int CCS_PPATH_BIT = 3;
	localparam int CCS_VREG_BIT = 2;
	localparam int CCS_THERM_BIT = 1;
	localparam int CCS_PGOOD_BIT = 0;

	// fault_thermal_status bit positions
	localparam int CCS_OVERV_BIT = 7;
	localparam int CCS_FAULT_RSVD_BIT = 6;
	localparam int CCS_OVERC_BIT = 5;
	localparam int CCS_UNDERV_BIT = 4;
	localparam int CCS_COLD_BIT = 3;
	localparam int CCS_COOL_BIT = 2;
	localparam int CCS_WARM_BIT = 1;
	localparam int CCS_HOT_BIT = 0;

	// value of both status bytes after reset, of reserved bits, of unmapped reads
	localparam logic [7:0] CCS_STATUS_RESET = 8'h00;
	localparam logic CCS_RSVD_VALUE = 1'b0;
	localparam logic [7:0] CCS_UNMAPPED_DATA = 8'h00;

	// ack level driven on the data line
	localparam logic CCS_SDA_LOW = 1'b0;

	// live comparator and charger-state signals from the analogue core
	typedef struct packed {
		logic taper_mode_active;
		logic charge_done_active;
		logic input_current_limit_active;
		logic power_path_regulation_active;
		logic input_voltage_regulation_active;
		logic thermal_regulation_active;
		logic vin_above_undervoltage;
		logic vin_above_bat_sleep;
		logic vin_below_overvoltage;
		logic input_overvoltage_active;
		logic battery_overcurrent_active;
		logic battery_undervoltage_active;
		logic ts_above_cold;
		logic ts_above_cool;
		logic ts_below_warm;
		logic ts_below_hot;
	} ccs_cond_s;

	typedef enum logic [3:0] {
		CCS_IDLE,
		CCS_ADDR,
		CCS_ADDR_ACK,
		CCS_PTR,
		CCS_PTR_ACK,
		CCS_WDATA,
		CCS_WDATA_ACK,
		CCS_RDATA,
		CCS_RD_ACK
	} ccs_state_e;

endpackage
`default_nettype wire

// >>> ccs_status_capture.sv
/*
 * Samples the live charger conditions into the two read-only status
 * bytes every clock and presents the byte addressed by the register
 * pointer on a registered read port.
 * Assumes the condition inputs are synchronous to clk.
 */
`timescale 1ns/10ps
`default_nettype none
module ccs_status_capture
	import ccs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire ccs_cond_s cond,
	input wire logic [7:0] rd_ptr,
	output logic [7:0] rd_data
);

	logic [7:0] live;
	logic [7:0] fault;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			live <= CCS_STATUS_RESET;
		end else begin
			live[CCS_LIVE_RSVD_BIT] <= CCS_RSVD_VALUE;
			live[CCS_TAPER_BIT] <= cond.taper_mode_active;
			live[CCS_DONE_BIT] <= cond.charge_done_active;
			live[CCS_ILIM_BIT] <= cond.input_current_limit_active;
			live[CCS_PPATH_BIT] <= cond.power_path_regulation_active;
			live[CCS_VREG_BIT] <= cond.input_voltage_regulation_active;
			live[CCS_THERM_BIT] <= cond.thermal_regulation_active;
			live[CCS_PGOOD_BIT] <= cond.vin_above_undervoltage & cond.vin_above_bat_sleep
				& cond.vin_below_overvoltage;
		end
	end

	// regions come from threshold comparators; cold masks cool and hot masks warm
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fault <= CCS_STATUS_RESET;
		end else begin
			fault[CCS_OVERV_BIT] <= cond.input_overvoltage_active;
			fault[CCS_FAULT_RSVD_BIT] <= CCS_RSVD_VALUE;
			fault[CCS_OVERC_BIT] <= cond.battery_overcurrent_active;
			fault[CCS_UNDERV_BIT] <= cond.battery_undervoltage_active;
			fault[CCS_COLD_BIT] <= cond.ts_above_cold;
			fault[CCS_COOL_BIT] <= cond.ts_above_cool & ~cond.ts_above_cold;
			fault[CCS_WARM_BIT] <= cond.ts_below_warm & ~cond.ts_below_hot;
			fault[CCS_HOT_BIT] <= cond.ts_below_hot;
		end
	end

	// a read only selects, it never disturbs the sampled bits
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_data <= CCS_UNMAPPED_DATA;
		end else if (rd_ptr == CCS_LIVE_OFS) begin
			rd_data <= live;
		end else if (rd_ptr == CCS_FAULT_OFS) begin
			rd_data <= fault;
		end else begin
			rd_data <= CCS_UNMAPPED_DATA;
		end
	end

endmodule
`default_nettype wire

// >>> ccs_status_target_sva.sv
/*
 * Pin-level checks of the status target's serial side.
 * Assumes SCL phases of at least four CLK periods; bound to the top.
 */
`timescale 1ns/10ps
`default_nettype none
module ccs_status_target_sva
	import ccs_pkg::*;
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic SCL,
	input wire logic SDA_I,
	input wire logic SDA_O,
	input wire logic SDA_OE,
	input wire ccs_cond_s COND
);
	logic scl_q;
	logic sda_q;
	logic [4:0] cnt;
	logic [7:0] shreg;
	logic match;
	logic wr;
	assign match = shreg[7:1] == CCS_TARGET_ADDR;
	assign wr = match && !shreg[0];
	always_ff @(posedge CLK) begin
		scl_q <= SCL;
		sda_q <= SDA_I;
	end
	// counts SCL rises since the last start, saturating so long reads stay put
	always_ff @(posedge CLK) begin
		if (!RSTN || (SCL && scl_q && sda_q && !SDA_I)) begin
			cnt <= 5'h00;
			shreg <= 8'h00;
		end else if (SCL && !scl_q && cnt != 5'h1F) begin
			cnt <= cnt + 5'h01;
			if (cnt < 5'h08)
				shreg <= {shreg[6:0], SDA_I};
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	sequence s_addr_done;
		$fell(SCL) && cnt == 5'h08 && match;
	endsequence
	sequence s_ptr_done;
		$fell(SCL) && cnt == 5'h11 && wr;
	endsequence
	sequence s_rd_done;
		$fell(SCL) && cnt == 5'h11 && match && shreg[0];
	endsequence
	sequence s_ack_held;
		##[1:4] SDA_OE ##1 SDA_OE [*3];
	endsequence
	chk_sdo_level: assert property (SDA_O == CCS_SDA_LOW)
		else $error("data output not low");
	chk_addr_quiet: assert property (cnt < 5'h08 |-> !SDA_OE)
		else $error("wire driven during address byte");
	chk_addr_nak: assert property (cnt >= 5'h08 && !match |-> !SDA_OE)
		else $error("foreign address answered");
	chk_addr_ack: assert property (s_addr_done |-> s_ack_held)
		else $error("own address not acknowledged");
	chk_ptr_ack: assert property (s_ptr_done |-> s_ack_held)
		else $error("pointer byte not acknowledged");
	chk_write_quiet: assert property (wr && cnt inside {[5'h0A:5'h10]} |-> !SDA_OE)
		else $error("wire driven during pointer byte");
	chk_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL && !$past(SCL))
		else $error("data changed while clock high");
	chk_rd_release: assert property (s_rd_done |-> ##[1:4] !SDA_OE ##1 !SDA_OE [*3])
		else $error("wire not released after read byte");
endmodule
bind ccs_status_target ccs_status_target_sva chk (.CLK(CLK), .RSTN(RSTN), .SCL(SCL),
	.SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .COND(COND));
`default_nettype wire

// >>> ccs_host_model.sv
/*
 * Serial host model: start, stop and nine-bit transfers.
 * Assumes the bench resolves the pulled-up data wire from all enables.
 */
`timescale 1ns/10ps
`default_nettype none
module ccs_host_model (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic pull
);
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end
	// every change lands just after a clock edge, eight clocks per phase
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic start();
		pull = 1'b0;
		tick(8);
		scl = 1'b1;
		tick(8);
		pull = 1'b1;
		tick(8);
		scl = 1'b0;
	endtask
	task automatic stop();
		pull = 1'b1;
		tick(8);
		scl = 1'b1;
		tick(8);
		pull = 1'b0;
		tick(8);
	endtask
	task automatic bit_io(input logic b, output logic r);
		pull = !b;
		tick(8);
		scl = 1'b1;
		tick(4);
		r = sda;
		tick(4);
		scl = 1'b0;
	endtask
	// bit 0 of w is the ack slot: 1 releases it, 0 acknowledges
	task automatic xfer(input logic [8:0] w, output logic [8:0] r);
		for (int i = 8; i >= 0; i--)
			bit_io(w[i], r[i]);
	endtask
endmodule
`default_nettype wire

// >>> ccs_status_target_test.sv
/*
 * Self-checking bench: random and corner conditions read back serially.
 * Assumes the host model and the bound pin checker.
 */
`timescale 1ns/10ps
`default_nettype none
module ccs_status_target_test
	import ccs_pkg::*;
;
	logic CLK;
	logic RSTN;
	logic scl;
	logic pull;
	logic sda;
	logic sda_o;
	logic sda_oe;
	ccs_cond_s cond;
	int error_cnt = 0;
	int cmp_count = 0;
	logic [8:0] r;
	logic [15:0] corner [8] = '{16'h0000, 16'hFFFF, 16'h0380, 16'h0300,
		16'h000C, 16'h0004, 16'h0002, 16'h0003};
	// pulled-up wire, low when either side pulls
	assign sda = !(pull || sda_oe);
	ccs_status_target dut (.CLK(CLK), .RSTN(RSTN), .SCL(scl), .SDA_I(sda),
		.SDA_O(sda_o), .SDA_OE(sda_oe), .COND(cond));
	ccs_host_model host (.clk(CLK), .sda(sda), .scl(scl), .pull(pull));
	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end
	function automatic logic [7:0] exp_reg(ccs_cond_s c, logic [7:0] a);
		case (a)
			CCS_LIVE_OFS: return {CCS_RSVD_VALUE, c.taper_mode_active,
				c.charge_done_active, c.input_current_limit_active,
				c.power_path_regulation_active, c.input_voltage_regulation_active,
				c.thermal_regulation_active, c.vin_above_undervoltage &
				c.vin_above_bat_sleep & c.vin_below_overvoltage};
			CCS_FAULT_OFS: return {c.input_overvoltage_active, CCS_RSVD_VALUE,
				c.battery_overcurrent_active, c.battery_undervoltage_active,
				c.ts_above_cold, c.ts_above_cool & !c.ts_above_cold,
				c.ts_below_warm & !c.ts_below_hot, c.ts_below_hot};
			default: return CCS_UNMAPPED_DATA;
		endcase
	endfunction
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares=%0d errors=%0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic set_ptr(input logic [7:0] a);
		host.start();
		host.xfer({CCS_TARGET_ADDR, 1'b0, 1'b1}, r);
		cmp8({7'h00, r[0]}, 8'h00);
		host.xfer({a, 1'b1}, r);
		cmp8({7'h00, r[0]}, 8'h00);
	endtask
	task automatic rd_from(input logic [7:0] a, input int n);
		set_ptr(a);
		host.start();
		host.xfer({CCS_TARGET_ADDR, 1'b1, 1'b1}, r);
		cmp8({7'h00, r[0]}, 8'h00);
		for (int i = 0; i < n; i++) begin
			host.xfer({8'hFF, i == n - 1}, r);
			cmp8(r[8:1], exp_reg(cond, a + 8'(i)));
		end
		host.stop();
	endtask
	initial begin
		RSTN = 1'b0;
		cond = '0;
		void'($urandom(90));
		repeat (6) @(posedge CLK);
		#1;
		RSTN = 1'b1;
		repeat (4) @(posedge CLK);
		#1;
		for (int k = 0; k < 12; k++) begin
			cond = (k < 8) ? ccs_cond_s'(corner[k]) : ccs_cond_s'(16'($urandom));
			repeat (3) @(posedge CLK);
			#1;
			// a write to a read-only byte is taken but must not stick
			set_ptr(k[0] ? CCS_FAULT_OFS : CCS_LIVE_OFS);
			host.xfer({8'($urandom), 1'b1}, r);
			cmp8({7'h00, r[0]}, 8'h00);
			host.stop();
			repeat (2) rd_from(CCS_LIVE_OFS, 3);
		end
		rd_from(8'hFF, 2);
		host.start();
		host.xfer({CCS_TARGET_ADDR ^ 7'h01, 1'b0, 1'b1}, r);
		cmp8({7'h00, r[0]}, 8'h01);
		host.stop();
		tally_and_finish();
	end
	initial begin
		repeat (80000) @(posedge CLK);
		error_cnt++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
